//--- dv/test_pcs_clock_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
`include "pcs_defines.svh"
module test_pcs_clock_ctrl;
  import pcs_pkg::*;

  logic        clk_sys;
  logic        sys_rst;
  logic        reg_wr;
  logic        reg_rd;
  pcs_addr_t   reg_addr;
  pcs_word_t   reg_wdata;
  pcs_word_t   reg_rdata_q;
  logic [7:0]  src_q;
  logic        ext_rx;
  logic        ext_tx;
  logic        clr_q;
  wire  [10:0] outs;
  int          cyc;
  int          err_total;
  int          total_checks;
  int          cnt [11];

  pcs_clock_ctrl #(.DIV_W(16)) u_pcs_clock_ctrl (
    .clk_sys(clk_sys), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_q(reg_rdata_q),
    .audio_src_tick(src_q[0]), .high_freq_oscillator(src_q[0]), .clock_24mhz(src_q[1]),
    .core_pll_tick(src_q[2]), .clock_32khz(src_q[3]), .clock_48mhz(src_q[4]),
    .cpu_tick(src_q[5]), .dac_tick(src_q[6]), .dac_adc_loop_tick(src_q[7]),
    .external_audio_rx_clock(ext_rx), .external_audio_tx_clock(ext_tx),
    .audio_base_tick(outs[`PCS_CH_BASE]), .audio_tx_tick(outs[`PCS_CH_TX]),
    .audio_rx_tick(outs[`PCS_CH_RX]), .uart0_tick(outs[`PCS_CH_UART0]),
    .uart1_tick(outs[`PCS_CH_UART1]), .card0_tick(outs[`PCS_CH_CARD0]),
    .card1_tick(outs[`PCS_CH_CARD1]), .panel_tick(outs[`PCS_CH_PANEL]),
    .segment_tick(outs[`PCS_CH_SEGMENT]), .spi0_tick(outs[`PCS_CH_SPI0]),
    .spi1_tick(outs[`PCS_CH_SPI1])
  );

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // source i pulses every i+1 cycles so each pick gives a distinct rate
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    for (int i = 0; i < 8; i++) src_q[i] <= (cyc % (i + 1)) == 0;
    if (cyc % 8 == 0) begin
      ext_rx <= ~ext_rx;
      ext_tx <= ~ext_tx;
    end
    for (int i = 0; i < 11; i++) cnt[i] <= clr_q ? 0 : cnt[i] + int'(outs[i]);
  end

  task automatic check(input pcs_word_t seen, input pcs_word_t want);
    total_checks++;
    if (seen !== want) begin
      err_total++;
      $display("MISMATCH %0t read %h expected %h", $time, seen, want);
    end
  endtask : check

  // pulse counts may be off by one at the window edges
  task automatic meas(input int ch, input int settle, input int win, input int want);
    int d;
    repeat (settle) @(posedge clk_sys);
    clr_q <= 1'b1;
    @(posedge clk_sys);
    clr_q <= 1'b0;
    repeat (win) @(posedge clk_sys);
    #1 d = cnt[ch] - want;
    total_checks++;
    if (d > 1 || d < -1) begin
      err_total++;
      $display("MISMATCH %0t channel %0d pulses %0d expected %0d", $time, ch, cnt[ch], want);
    end
  endtask : meas

  task automatic wr(input pcs_addr_t a, input pcs_word_t v);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd_chk(input pcs_addr_t a, input pcs_word_t want);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 check(reg_rdata_q, want);
  endtask : rd_chk

  task automatic do_reset;
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
  endtask : do_reset

  task automatic t_regs;
    pcs_addr_t offs [7] = '{`PCS_OFF_AUDIO, `PCS_OFF_UART, `PCS_OFF_CARD0, `PCS_OFF_CARD1,
                            `PCS_OFF_PANEL, `PCS_OFF_SEGMENT, `PCS_OFF_SPI};
    pcs_word_t msk [7] = '{32'h0000_0377, 32'h0000_0011, 32'h0000_0117, 32'h0000_0117,
                           32'h0000_0017, 32'h0000_001f, 32'h0000_dfdf};
    do_reset();
    for (int i = 0; i < 7; i++) rd_chk(offs[i], i == 0 ? 32'h0000_0010 : 32'h0000_0000);
    for (int i = 0; i < 7; i++) begin
      wr(offs[i], 32'hffff_ffff);
      rd_chk(offs[i], msk[i]);
    end
    wr(8'h2c, 32'hffff_ffff);
    rd_chk(8'h2c, 32'h0000_0000);
  endtask : t_regs

  task automatic t_uart;
    pcs_word_t v [3] = '{32'h0000_0000, 32'h0000_0011, 32'h0000_0010};
    do_reset();
    for (int i = 0; i < 3; i++) begin
      wr(`PCS_OFF_UART, v[i]);
      meas(`PCS_CH_UART0, 8, 64, v[i][0] ? 32 : 64);
      meas(`PCS_CH_UART1, 1, 64, v[i][4] ? 32 : 64);
    end
  endtask : t_uart

  task automatic t_card;
    for (int c = 0; c < 2; c++) begin
      do_reset();
      for (int d = 0; d < 8; d++) begin
        wr(c ? `PCS_OFF_CARD1 : `PCS_OFF_CARD0, d);
        meas(`PCS_CH_CARD0 + c, 12, 120, 120 / (d + 1));
      end
      wr(c ? `PCS_OFF_CARD1 : `PCS_OFF_CARD0, 32'h0000_0011);
      meas(`PCS_CH_CARD0 + c, 24, 120, 20);
      wr(c ? `PCS_OFF_CARD1 : `PCS_OFF_CARD0, 32'h0000_0100);
      meas(`PCS_CH_CARD0 + c, 16, 1024, 4);
    end
  endtask : t_card

  task automatic t_panel;
    do_reset();
    for (int d = 0; d < 8; d++) begin
      wr(`PCS_OFF_PANEL, d);
      meas(`PCS_CH_PANEL, 70, 256, d == 7 ? 0 : 256 >> d);
    end
    // a period frozen by the reserved code must finish first: up to 64 pll pulses
    wr(`PCS_OFF_PANEL, 32'h0000_0010);
    meas(`PCS_CH_PANEL, 200, 255, 85);
  endtask : t_panel

  task automatic t_segment;
    do_reset();
    for (int d = 0; d < 8; d++) begin
      wr(`PCS_OFF_SEGMENT, 32'h0000_0010 | d);
      meas(`PCS_CH_SEGMENT, 40, 256, d > 5 ? 0 : 256 >> d);
    end
    wr(`PCS_OFF_SEGMENT, 32'h0000_0000);
    meas(`PCS_CH_SEGMENT, 40, 256, 64);
    wr(`PCS_OFF_SEGMENT, 32'h0000_0018);
    meas(`PCS_CH_SEGMENT, 8, 2048, 4);
  endtask : t_segment

  // the two fields get opposite picks so a swapped field shows up
  task automatic t_spi;
    int per [4] = '{6, 1, 3, 5};
    int code [4] = '{2, 29, 30, 31};
    int want [4] = '{80, 8, 160, 96};
    do_reset();
    for (int s = 0; s < 4; s++) begin
      wr(`PCS_OFF_SPI, (s << 6) | ((3 - s) << 14));
      meas(`PCS_CH_SPI0, 40, 240, 240 / per[s]);
      meas(`PCS_CH_SPI1, 1, 240, 240 / per[3 - s]);
    end
    for (int i = 0; i < 4; i++) begin
      wr(`PCS_OFF_SPI, 32'h0000_4040 | code[i] | (code[i] << 8));
      meas(`PCS_CH_SPI0, 40, 240, want[i]);
      meas(`PCS_CH_SPI1, 1, 240, want[i]);
    end
  endtask : t_spi

  // external pins rise every 16 cycles, loopback every 8, dac every 7
  task automatic t_audio;
    int texp [4] = '{0, 30, 15, 0};
    int rexp [4] = '{0, 34, 15, 0};
    do_reset();
    wr(`PCS_OFF_AUDIO, 32'h0000_0001);
    meas(`PCS_CH_BASE, 20, 240, 120);
    meas(`PCS_CH_TX, 1, 240, 120);
    meas(`PCS_CH_RX, 1, 240, 120);
    wr(`PCS_OFF_AUDIO, 32'h0000_0041);
    meas(`PCS_CH_TX, 20, 240, 60);
    for (int s = 1; s < 4; s++) begin
      wr(`PCS_OFF_AUDIO, (s << 8) | (s << 4) | 1);
      meas(`PCS_CH_TX, 40, 240, texp[s]);
      meas(`PCS_CH_RX, 1, 240, rexp[s]);
    end
  endtask : t_audio

  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : stop_test

  // watchdog well above the roughly 20k cycles the scenarios need
  initial begin
    repeat (80000) @(posedge clk_sys);
    err_total++;
    stop_test();
  end

  initial begin
    sys_rst      = 1'b1;
    reg_wr       = 1'b0;
    reg_rd       = 1'b0;
    reg_addr     = '0;
    reg_wdata    = '0;
    src_q        = '0;
    ext_rx       = 1'b0;
    ext_tx       = 1'b0;
    clr_q        = 1'b0;
    cyc          = 0;
    err_total    = 0;
    total_checks = 0;
    foreach (cnt[i]) cnt[i] = 0;
    repeat (20) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_regs();
    t_uart();
    t_card();
    t_panel();
    t_segment();
    t_spi();
    t_audio();
    stop_test();
  end
endmodule : test_pcs_clock_ctrl
`default_nettype wire

//--- src/pcs_clock_ctrl.sv
// Design decision made here: the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
`include "pcs_defines.svh"
// Contract
// - audio rx source: base, dac, external pin
// - audio tx halver: /1 clear, /2 set
// - audio tx source, reset value one
// - three-bit divisor makes audio base clock
// - uart1 select: oscillator or 24 MHz
// - uart0 select likewise, both reset zero
// - card0 optional extra divide by 256
// - card0 source: oscillator or core pll
// - card0 divides by field plus one
// - card1 same layout as card0
// - panel source: oscillator or core pll
// - panel divides by power of two
// - segment source: 32 kHz or oscillator
// - segment optional extra divide by 512
// - segment power-of-two divide up to 32
// - spi1 four-way source select
// - spi1 divides value plus one, fractional codes
// - spi0 four-way source select
// - spi0 divides value plus one, fractional codes
module pcs_clock_ctrl #(
  parameter int DIV_W = 16
) (
  // system
  input  wire logic               clk_sys,
  input  wire logic               sys_rst,
  // register port
  input  wire pcs_pkg::pcs_addr_t reg_addr,
  input  wire pcs_pkg::pcs_word_t reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output var  pcs_pkg::pcs_word_t reg_rdata_q,
  // source clock enables, one-cycle pulses on clk_sys
  input  wire logic               audio_src_tick,
  input  wire logic               high_freq_oscillator,
  input  wire logic               clock_24mhz,
  input  wire logic               clock_32khz,
  input  wire logic               clock_48mhz,
  input  wire logic               core_pll_tick,
  input  wire logic               cpu_tick,
  input  wire logic               dac_tick,
  input  wire logic               dac_adc_loop_tick,
  // external audio clock pins, asynchronous
  input  wire logic               external_audio_rx_clock,
  input  wire logic               external_audio_tx_clock,
  // peripheral clock enables
  output var  logic               audio_base_tick,
  output var  logic               audio_tx_tick,
  output var  logic               audio_rx_tick,
  output var  logic               uart0_tick,
  output var  logic               uart1_tick,
  output var  logic               card0_tick,
  output var  logic               card1_tick,
  output var  logic               panel_tick,
  output var  logic               segment_tick,
  output var  logic               spi0_tick,
  output var  logic               spi1_tick
);
  import pcs_pkg::*;

  pcs_word_t        cfg_q [`PCS_NUM_REGS];
  logic [3:0]       wr_dec;
  logic [3:0]       rd_dec;
  logic             ext_rx_tick;
  logic             ext_tx_tick;
  logic             src_v   [`PCS_NUM_CH];
  logic [DIV_W-1:0] ratio_m [`PCS_NUM_CH];
  pcs_k_t           ratio_k [`PCS_NUM_CH];
  logic             tick_q  [`PCS_NUM_CH];

  // named fields
  logic [1:0] audio_rx_source_pick;
  logic       audio_tx_halver;
  logic [1:0] audio_tx_source_pick;
  logic [2:0] audio_base_divisor;
  logic [2:0] card0_divisor;
  logic [2:0] panel_divisor;
  logic [2:0] segment_pow2_divisor;
  logic       card0_div256_enable;

  assign audio_rx_source_pick = cfg_q[`PCS_IDX_AUDIO][`PCS_F_AUD_RX];
  assign audio_tx_halver      = cfg_q[`PCS_IDX_AUDIO][`PCS_F_AUD_HALVE];
  assign audio_tx_source_pick = cfg_q[`PCS_IDX_AUDIO][`PCS_F_AUD_TX];
  assign audio_base_divisor   = cfg_q[`PCS_IDX_AUDIO][`PCS_F_AUD_DIV];
  assign card0_divisor        = cfg_q[`PCS_IDX_CARD0][`PCS_F_CARD_DIV];
  assign card0_div256_enable  = cfg_q[`PCS_IDX_CARD0][`PCS_F_CARD_D256];
  assign panel_divisor        = cfg_q[`PCS_IDX_PANEL][`PCS_F_PANEL_DIV];
  assign segment_pow2_divisor = cfg_q[`PCS_IDX_SEGMENT][`PCS_F_SEG_DIV];

  // address decode shared by the write and read paths: {hit, index}
  function automatic logic [3:0] pcs_decode(input pcs_addr_t a);
    case (a)
      `PCS_OFF_AUDIO:   pcs_decode = {1'b1, `PCS_IDX_AUDIO};
      `PCS_OFF_UART:    pcs_decode = {1'b1, `PCS_IDX_UART};
      `PCS_OFF_CARD0:   pcs_decode = {1'b1, `PCS_IDX_CARD0};
      `PCS_OFF_CARD1:   pcs_decode = {1'b1, `PCS_IDX_CARD1};
      `PCS_OFF_PANEL:   pcs_decode = {1'b1, `PCS_IDX_PANEL};
      `PCS_OFF_SEGMENT: pcs_decode = {1'b1, `PCS_IDX_SEGMENT};
      `PCS_OFF_SPI:     pcs_decode = {1'b1, `PCS_IDX_SPI};
      default:          pcs_decode = 4'h0;
    endcase
  endfunction : pcs_decode

  // writable bits per register
  function automatic pcs_word_t pcs_mask(input int idx);
    case (idx)
      0:       pcs_mask = `PCS_MASK_AUDIO;
      1:       pcs_mask = `PCS_MASK_UART;
      2, 3:    pcs_mask = `PCS_MASK_CARD;
      4:       pcs_mask = `PCS_MASK_PANEL;
      5:       pcs_mask = `PCS_MASK_SEGMENT;
      6:       pcs_mask = `PCS_MASK_SPI;
      default: pcs_mask = `PCS_RST_ZERO;
    endcase
  endfunction : pcs_mask

  // card ratio: (div + 1), optionally times 256
  function automatic logic [DIV_W-1:0] card_ratio(input pcs_word_t r);
    logic [DIV_W-1:0] base;
    base = DIV_W'(r[`PCS_F_CARD_DIV]) + DIV_W'(1);
    card_ratio = r[`PCS_F_CARD_D256] ? DIV_W'(base << `PCS_CARD_SHIFT) : base;
  endfunction : card_ratio

  // spi ratio as m over k: value plus one, or 3/2 and 5/2
  function automatic logic [DIV_W+1:0] spi_ratio(input logic [4:0] d);
    case (d)
      `PCS_SPI_FRAC15: spi_ratio = {`PCS_FRAC_K, DIV_W'(`PCS_FRAC15_M)};
      `PCS_SPI_FRAC25: spi_ratio = {`PCS_FRAC_K, DIV_W'(`PCS_FRAC25_M)};
      default:         spi_ratio = {`PCS_INT_K, DIV_W'(d) + DIV_W'(1)};
    endcase
  endfunction : spi_ratio

  // spi four-way source choice
  function automatic logic spi_src(input logic [1:0] s, input logic cpu,
                                   input logic osc, input logic pll,
                                   input logic c48);
    case (s)
      `PCS_SPI_CPU:  spi_src = cpu;
      `PCS_SPI_OSC:  spi_src = osc;
      `PCS_SPI_PLL:  spi_src = pll;
      default:       spi_src = c48;
    endcase
  endfunction : spi_src

  assign wr_dec = pcs_decode(reg_addr);
  assign rd_dec = pcs_decode(reg_addr);

  // register array; masking keeps reserved bits at zero whatever is written
  for (genvar i = 0; i < `PCS_NUM_REGS; i++) begin : g_reg
    always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
        cfg_q[i] <= (i == 0) ? `PCS_RST_AUDIO : `PCS_RST_ZERO;
      end else if (reg_wr && wr_dec[3] && (wr_dec[2:0] == 3'(i))) begin
        cfg_q[i] <= reg_wdata & pcs_mask(i);
      end
    end
  end

  // read data stands for one cycle only; unmapped offsets read zero
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      reg_rdata_q <= `PCS_RST_ZERO;
    end else if (reg_rd && rd_dec[3]) begin
      reg_rdata_q <= cfg_q[rd_dec[2:0]];
    end else begin
      reg_rdata_q <= `PCS_RST_ZERO;
    end
  end

  // external audio clocks become enables after synchronising
  pcs_pin_tick u_rx_pin (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .pin_in  (external_audio_rx_clock),
    .tick_q  (ext_rx_tick)
  );

  pcs_pin_tick u_tx_pin (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .pin_in  (external_audio_tx_clock),
    .tick_q  (ext_tx_tick)
  );

  // source choice and ratio of every channel; reserved codes stop the output
  always_comb begin
    for (int c = 0; c < `PCS_NUM_CH; c++) begin
      ratio_m[c] = DIV_W'(1);
      ratio_k[c] = `PCS_INT_K;
    end
    // audio base clock
    src_v[`PCS_CH_BASE]   = audio_src_tick;
    ratio_m[`PCS_CH_BASE] = DIV_W'(audio_base_divisor) + DIV_W'(1);
    // audio transmit
    case (audio_tx_source_pick)
      `PCS_SRC_BASE:     src_v[`PCS_CH_TX] = tick_q[`PCS_CH_BASE];
      `PCS_SRC_INTERNAL: src_v[`PCS_CH_TX] = dac_adc_loop_tick;
      `PCS_SRC_EXTERNAL: src_v[`PCS_CH_TX] = ext_tx_tick;
      default:           src_v[`PCS_CH_TX] = 1'b0;
    endcase
    ratio_m[`PCS_CH_TX] = audio_tx_halver ? DIV_W'(2) : DIV_W'(1);
    // audio receive
    case (audio_rx_source_pick)
      `PCS_SRC_BASE:     src_v[`PCS_CH_RX] = tick_q[`PCS_CH_BASE];
      `PCS_SRC_INTERNAL: src_v[`PCS_CH_RX] = dac_tick;
      `PCS_SRC_EXTERNAL: src_v[`PCS_CH_RX] = ext_rx_tick;
      default:           src_v[`PCS_CH_RX] = 1'b0;
    endcase
    // uarts
    src_v[`PCS_CH_UART0] = cfg_q[`PCS_IDX_UART][`PCS_F_UART0_SEL] ?
                           clock_24mhz : high_freq_oscillator;
    src_v[`PCS_CH_UART1] = cfg_q[`PCS_IDX_UART][`PCS_F_UART1_SEL] ?
                           clock_24mhz : high_freq_oscillator;
    // card controllers
    src_v[`PCS_CH_CARD0]   = cfg_q[`PCS_IDX_CARD0][`PCS_F_CARD_SEL] ?
                             core_pll_tick : high_freq_oscillator;
    ratio_m[`PCS_CH_CARD0] = card_ratio(cfg_q[`PCS_IDX_CARD0]);
    src_v[`PCS_CH_CARD1]   = cfg_q[`PCS_IDX_CARD1][`PCS_F_CARD_SEL] ?
                             core_pll_tick : high_freq_oscillator;
    ratio_m[`PCS_CH_CARD1] = card_ratio(cfg_q[`PCS_IDX_CARD1]);
    // panel
    src_v[`PCS_CH_PANEL]   = (panel_divisor != `PCS_PANEL_RSVD) &&
                             (cfg_q[`PCS_IDX_PANEL][`PCS_F_PANEL_SEL] ?
                              core_pll_tick : high_freq_oscillator);
    ratio_m[`PCS_CH_PANEL] = DIV_W'(DIV_W'(1) << panel_divisor);
    // segment display
    src_v[`PCS_CH_SEGMENT]   = (segment_pow2_divisor <= `PCS_SEG_MAX_DIV) &&
                               (cfg_q[`PCS_IDX_SEGMENT][`PCS_F_SEG_SEL] ?
                                high_freq_oscillator : clock_32khz);
    ratio_m[`PCS_CH_SEGMENT] = DIV_W'(DIV_W'(1) << segment_pow2_divisor);
    if (cfg_q[`PCS_IDX_SEGMENT][`PCS_F_SEG_D512]) begin
      ratio_m[`PCS_CH_SEGMENT] = DIV_W'(ratio_m[`PCS_CH_SEGMENT] << `PCS_SEG_SHIFT);
    end
    // serial peripheral ports
    src_v[`PCS_CH_SPI0] = spi_src(cfg_q[`PCS_IDX_SPI][`PCS_F_SPI0_SEL], cpu_tick,
                                  high_freq_oscillator, core_pll_tick,
                                  clock_48mhz);
    {ratio_k[`PCS_CH_SPI0], ratio_m[`PCS_CH_SPI0]} =
      spi_ratio(cfg_q[`PCS_IDX_SPI][`PCS_F_SPI0_DIV]);
    src_v[`PCS_CH_SPI1] = spi_src(cfg_q[`PCS_IDX_SPI][`PCS_F_SPI1_SEL], cpu_tick,
                                  high_freq_oscillator, core_pll_tick,
                                  clock_48mhz);
    {ratio_k[`PCS_CH_SPI1], ratio_m[`PCS_CH_SPI1]} =
      spi_ratio(cfg_q[`PCS_IDX_SPI][`PCS_F_SPI1_DIV]);
  end

  // one divider per channel; each retimes ratio changes to its own boundary
  for (genvar c = 0; c < `PCS_NUM_CH; c++) begin : g_div
    pcs_tick_div #(
      .DIV_W (DIV_W)
    ) u_div (
      .clk_sys  (clk_sys),
      .sys_rst  (sys_rst),
      .src_tick (src_v[c]),
      .ratio_m  (ratio_m[c]),
      .ratio_k  (ratio_k[c]),
      .tick_q   (tick_q[c])
    );
  end

  // ports come straight from the divider flops
  assign audio_base_tick = tick_q[`PCS_CH_BASE];
  assign audio_tx_tick   = tick_q[`PCS_CH_TX];
  assign audio_rx_tick   = tick_q[`PCS_CH_RX];
  assign uart0_tick      = tick_q[`PCS_CH_UART0];
  assign uart1_tick      = tick_q[`PCS_CH_UART1];
  assign card0_tick      = tick_q[`PCS_CH_CARD0];
  assign card1_tick      = tick_q[`PCS_CH_CARD1];
  assign panel_tick      = tick_q[`PCS_CH_PANEL];
  assign segment_tick    = tick_q[`PCS_CH_SEGMENT];
  assign spi0_tick       = tick_q[`PCS_CH_SPI0];
  assign spi1_tick       = tick_q[`PCS_CH_SPI1];

  // checks on the outputs against their programmed cause
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  for (genvar c = 0; c < `PCS_NUM_CH; c++) begin : g_chk
    tick_follow_src_a: assert property (tick_q[c] |-> $past(src_v[c]))
      else $error("output pulse without a selected source pulse");
  end

  aud_rx_rsvd_a: assert property ((audio_rx_source_pick == 2'h3) |=> !audio_rx_tick)
    else $error("audio rx runs on reserved source");

  rx_dac_route_a: assert property (
    (audio_rx_tick && $past(audio_rx_source_pick == `PCS_SRC_INTERNAL)) |-> $past(dac_tick))
    else $error("audio rx not on the dac clock");

  tx_halve_a: assert property ((audio_tx_tick && audio_tx_halver) |=> !audio_tx_tick)
    else $error("audio tx halver let two pulses through");

  tx_reset_val_a: assert property (
    $past(sys_rst) |-> (audio_tx_source_pick == `PCS_SRC_INTERNAL))
    else $error("audio tx source not one after reset");

  tx_loop_route_a: assert property (
    (audio_tx_tick && $past(audio_tx_source_pick == `PCS_SRC_INTERNAL))
      |-> $past(dac_adc_loop_tick))
    else $error("audio tx not on the loopback clock");

  base_div_a: assert property (
    (audio_base_tick && audio_base_divisor != 3'h0) |=> !audio_base_tick)
    else $error("audio base divisor ignored");

  card0_div_a: assert property (
    (card0_tick && (card0_divisor != 3'h0 || card0_div256_enable)) |=> !card0_tick)
    else $error("card0 divisor ignored");

  card0_route_a: assert property (
    (card0_tick && $past(cfg_q[`PCS_IDX_CARD0][`PCS_F_CARD_SEL])) |-> $past(core_pll_tick))
    else $error("card0 not on the core pll");

  panel_rsvd_a: assert property ((panel_divisor == `PCS_PANEL_RSVD) |=> !panel_tick)
    else $error("panel runs on reserved divisor");

  panel_route_a: assert property (
    (panel_tick && $past(cfg_q[`PCS_IDX_PANEL][`PCS_F_PANEL_SEL])) |-> $past(core_pll_tick))
    else $error("panel not on the core pll");

  seg_rsvd_a: assert property ((segment_pow2_divisor > `PCS_SEG_MAX_DIV) |=> !segment_tick)
    else $error("segment runs on reserved divisor");

  seg_route_a: assert property (
    (segment_tick && $past(!cfg_q[`PCS_IDX_SEGMENT][`PCS_F_SEG_SEL])) |-> $past(clock_32khz))
    else $error("segment not on the 32 kHz clock");

  rsvd_read_a: assert property (
    (reg_rd && reg_addr == `PCS_OFF_UART) |=> (reg_rdata_q & ~`PCS_MASK_UART) == `PCS_RST_ZERO)
    else $error("reserved uart bits read nonzero");

  uart_route_a: assert property (
    (uart0_tick && $past(!cfg_q[`PCS_IDX_UART][`PCS_F_UART0_SEL]))
      |-> $past(high_freq_oscillator))
    else $error("uart0 not on oscillator");

  uart1_route_a: assert property (
    (uart1_tick && $past(cfg_q[`PCS_IDX_UART][`PCS_F_UART1_SEL])) |-> $past(clock_24mhz))
    else $error("uart1 not on the 24 MHz clock");

  spi0_route_a: assert property (
    (spi0_tick && $past(cfg_q[`PCS_IDX_SPI][`PCS_F_SPI0_SEL] == `PCS_SPI_CPU))
      |-> $past(cpu_tick))
    else $error("spi0 not on the cpu clock");
endmodule : pcs_clock_ctrl
`default_nettype wire

//--- src/pcs_defines.svh
`ifndef PCS_DEFINES_SVH
`define PCS_DEFINES_SVH

// register byte offsets
`define PCS_OFF_AUDIO     8'h10
`define PCS_OFF_UART      8'h14
`define PCS_OFF_CARD0     8'h18
`define PCS_OFF_CARD1     8'h1c
`define PCS_OFF_PANEL     8'h20
`define PCS_OFF_SEGMENT   8'h24
`define PCS_OFF_SPI       8'h28

// register slots in the flop array
`define PCS_IDX_AUDIO     3'h0
`define PCS_IDX_UART      3'h1
`define PCS_IDX_CARD0     3'h2
`define PCS_IDX_CARD1     3'h3
`define PCS_IDX_PANEL     3'h4
`define PCS_IDX_SEGMENT   3'h5
`define PCS_IDX_SPI       3'h6
`define PCS_NUM_REGS      7

// writable bits of each register, everything else reads zero
`define PCS_MASK_AUDIO    32'h0000_0377
`define PCS_MASK_UART     32'h0000_0011
`define PCS_MASK_CARD     32'h0000_0117
`define PCS_MASK_PANEL    32'h0000_0017
`define PCS_MASK_SEGMENT  32'h0000_001f
`define PCS_MASK_SPI      32'h0000_dfdf

// reset values
`define PCS_RST_AUDIO     32'h0000_0010
`define PCS_RST_ZERO      32'h0000_0000

// field positions
`define PCS_F_AUD_RX      9:8
`define PCS_F_AUD_HALVE   6
`define PCS_F_AUD_TX      5:4
`define PCS_F_AUD_DIV     2:0
`define PCS_F_UART1_SEL   4
`define PCS_F_UART0_SEL   0
`define PCS_F_CARD_D256   8
`define PCS_F_CARD_SEL    4
`define PCS_F_CARD_DIV    2:0
`define PCS_F_PANEL_SEL   4
`define PCS_F_PANEL_DIV   2:0
`define PCS_F_SEG_SEL     4
`define PCS_F_SEG_D512    3
`define PCS_F_SEG_DIV     2:0
`define PCS_F_SPI1_SEL    15:14
`define PCS_F_SPI1_DIV    12:8
`define PCS_F_SPI0_SEL    7:6
`define PCS_F_SPI0_DIV    4:0

// field codes
`define PCS_SRC_BASE      2'h0
`define PCS_SRC_INTERNAL  2'h1
`define PCS_SRC_EXTERNAL  2'h2
`define PCS_SPI_CPU       2'h0
`define PCS_SPI_OSC       2'h1
`define PCS_SPI_PLL       2'h2
`define PCS_PANEL_RSVD    3'h7
`define PCS_SEG_MAX_DIV   3'h5
`define PCS_SPI_FRAC15    5'h1e
`define PCS_SPI_FRAC25    5'h1f

// extra divide stages as shift counts, fractional ratio terms
`define PCS_CARD_SHIFT    8
`define PCS_SEG_SHIFT     9
`define PCS_FRAC15_M      3
`define PCS_FRAC25_M      5
`define PCS_FRAC_K        2'h2
`define PCS_INT_K         2'h1

// output channels
`define PCS_CH_BASE       0
`define PCS_CH_TX         1
`define PCS_CH_RX         2
`define PCS_CH_UART0      3
`define PCS_CH_UART1      4
`define PCS_CH_CARD0      5
`define PCS_CH_CARD1      6
`define PCS_CH_PANEL      7
`define PCS_CH_SEGMENT    8
`define PCS_CH_SPI0       9
`define PCS_CH_SPI1       10
`define PCS_NUM_CH        11

`endif

//--- src/pcs_pin_tick.sv
`timescale 1ns/1ns
`default_nettype none
module pcs_pin_tick (
  // system
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  // pin in, rising-edge pulse out
  input  wire logic pin_in,
  output var  logic tick_q
);
  logic meta_q;
  logic sync_q;
  logic prev_q;

  // two-flop synchroniser; only sync_q and later are looked at
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // one pulse per rising edge of the pin
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      tick_q <= 1'b0;
    end else begin
      tick_q <= sync_q & ~prev_q;
    end
  end
endmodule : pcs_pin_tick
`default_nettype wire

//--- src/pcs_pkg.sv
package pcs_pkg;
  typedef logic [31:0] pcs_word_t;
  typedef logic [7:0]  pcs_addr_t;
  typedef logic [1:0]  pcs_k_t;
endpackage : pcs_pkg

//--- src/pcs_tick_div.sv
`timescale 1ns/1ns
`default_nettype none
module pcs_tick_div #(
  parameter int DIV_W = 16
) (
  // system
  input  wire logic               clk_sys,
  input  wire logic               sys_rst,
  // source and ratio: emit ratio_k pulses per ratio_m source pulses
  input  wire logic               src_tick,
  input  wire logic [DIV_W-1:0]   ratio_m,
  input  wire pcs_pkg::pcs_k_t    ratio_k,
  output var  logic               tick_q
);
  import pcs_pkg::*;

  logic [DIV_W-1:0] acc_q;
  logic [DIV_W-1:0] m_q;
  pcs_k_t           k_q;
  logic [DIV_W-1:0] m_eff;
  pcs_k_t           k_eff;
  logic [DIV_W:0]   sum;

  // a new ratio is only taken at a period boundary, so no runt output period
  always_comb begin
    m_eff = (acc_q == '0) ? ratio_m : m_q;
    k_eff = (acc_q == '0) ? ratio_k : k_q;
    sum   = {1'b0, acc_q} + {{(DIV_W-1){1'b0}}, k_eff};
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      m_q <= '0;
      k_q <= '0;
    end else if (acc_q == '0) begin
      m_q <= ratio_m;
      k_q <= ratio_k;
    end
  end

  // accumulate k per source pulse, emit when a full m is collected
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      acc_q  <= '0;
      tick_q <= 1'b0;
    end else if (src_tick && (sum >= {1'b0, m_eff})) begin
      acc_q  <= DIV_W'(sum - {1'b0, m_eff});
      tick_q <= 1'b1;
    end else if (src_tick) begin
      acc_q  <= DIV_W'(sum);
      tick_q <= 1'b0;
    end else begin
      tick_q <= 1'b0;
    end
  end
endmodule : pcs_tick_div
`default_nettype wire
